// ### src/clp_pkg.sv
package clp_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int EXEC_TIME_NS = 18500;
	localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LONG_TIME_NS = 760000;
	localparam int LONG_CYCLES_DEF = (LONG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLINK_TIME_NS = 400000000;
	localparam int BLINK_CYCLES_DEF = BLINK_TIME_NS / CLK_PERIOD_NS;
	localparam int LINE_TIME_NS = 250000;
	localparam int LINE_CYCLES_DEF = LINE_TIME_NS / CLK_PERIOD_NS;

	// command decode bit positions
	localparam int CMD_DDADDR_BIT = 7;
	localparam int CMD_CGADDR_BIT = 6;
	localparam int CMD_FUNC_BIT = 5;
	localparam int CMD_SHIFT_BIT = 4;
	localparam int CMD_DISP_BIT = 3;
	localparam int CMD_ENTRY_BIT = 2;
	localparam int CMD_HOME_BIT = 1;
	localparam int CMD_CLEAR_BIT = 0;

	// command field positions
	localparam int FLD_DL = 4;
	localparam int FLD_N = 3;
	localparam int FLD_F = 2;
	localparam int FLD_SC = 3;
	localparam int FLD_RL = 2;
	localparam int FLD_DISP_ON = 2;
	localparam int FLD_CURSOR = 1;
	localparam int FLD_BLINK = 0;
	localparam int FLD_ID = 1;
	localparam int FLD_S = 0;
	localparam int STATUS_BUSY_BIT = 7;

	// address map
	localparam logic [6:0] ADDR_FIRST = 7'h00;
	localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
	localparam logic [6:0] LINE1_LAST = 7'h27;
	localparam logic [6:0] LINE2_FIRST = 7'h40;
	localparam logic [6:0] LINE2_LAST = 7'h67;
	localparam logic [6:0] ONE_LINE_LEN = 7'h50;
	localparam logic [6:0] TWO_LINE_LEN = 7'h28;
	localparam logic [6:0] ADDR_TOP = 7'h7F;

	// reset values and fill
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CLEAR_CHAR = 8'h20;
	localparam logic [1:0] PSEL_PARALLEL = 2'b00;
	localparam logic [3:0] USER_GLYPH_HI = 4'h0;

	// panel geometry
	localparam int CHAR_AW = 7;
	localparam int GLYPH_AW = 6;
	localparam int SEG_COUNT = 40;
	localparam int SEG_PER_CHAR = 5;
	localparam logic [2:0] LAST_POS = 3'h7;
	localparam logic [2:0] LAST_SEG_BIT = 3'h4;
	localparam logic [3:0] LAST_COM_ONE = 4'h7;
	localparam logic [3:0] LAST_COM_TWO = 4'hF;
	localparam logic [2:0] CURSOR_ROW = 3'h7;

	typedef enum logic [2:0] {E_IDLE, E_CLEAR, E_FETCH, E_CAPT, E_EXEC} clp_eng_t;
	typedef enum logic [2:0] {S_ADDR, S_CODE, S_GLYPH, S_ROW, S_SHIFT, S_LOAD, S_WAIT} clp_scan_t;

endpackage

// ### src/clp_dpram.sv
`timescale 1ns/1ps
module clp_dpram #(
	parameter int W  = 8,
	parameter int AW = 7
) (
	// clock
	input  wire logic          sys_clk,
	// read-write port
	input  wire logic [AW-1:0] a_addr,
	input  wire logic          a_we,
	input  wire logic [W-1:0]  a_wdata,
	output logic      [W-1:0]  a_rdata,
	// read port
	input  wire logic [AW-1:0] b_addr,
	output logic      [W-1:0]  b_rdata
);

	if (W < 1 || AW < 1 || AW > 16) begin : g_bad
		$error("clp_dpram: unsupported width or depth");
	end

	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge sys_clk) begin
		if (a_we) begin
			mem[a_addr] <= a_wdata;
		end
		a_rdata <= mem[a_addr];
		b_rdata <= mem[b_addr];
	end

endmodule

// ### src/clp_buf2.sv
`timescale 1ns/1ps
module clp_buf2 #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         arst_n,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	if (W < 1) begin : g_bad
		$error("clp_buf2: width must be positive");
	end

	logic [W-1:0] slot_r [0:1];
	logic         wr_ptr_r;
	logic         rd_ptr_r;
	logic [1:0]   count_r;
	wire          push = in_valid & in_ready;
	wire          pop  = out_valid & out_ready;

	assign in_ready  = (count_r != 2'h2);
	assign out_valid = (count_r != 2'h0);
	assign out_data  = slot_r[rd_ptr_r];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			slot_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r  <= 2'h0;
		end else begin
			wr_ptr_r <= wr_ptr_r ^ push;
			rd_ptr_r <= rd_ptr_r ^ pop;
			count_r  <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule

// ### src/clp_host_port.sv
`timescale 1ns/1ps
// Operation
// - data holding and command registers carry transfers
// - command register is write only
// - select 0, write 0 latches a command
// - select 0, read gives busy and counter
// - select 1, write 0 latches data byte
// - select 1, read returns data holding register
// - data read prefetches next RAM byte
// - data write stores byte into RAM
// - pins pick parallel, width bit picks 4/8
// - busy blocks commands; parallel modes only
// - character RAM up to 80 bytes; here 128 bytes, maps use 80
// - one-line map contiguous, shift wraps 4F
// - two-line map 00-27 and 40-67
// - two-line shift wraps within each line
// - address counter loaded by set-address commands
// - counter steps by one after access
// - 16 or 8 commons, 40 segments
// - serial segment chain, parallel holding latch
// - fixed glyph ROM 256 codes, 5x8
// - cursor on/off, blink, inversion at cursor
// - code bits 2:0 form glyph address 5:3
// - bit 7 command loads counter, selects characters
module clp_host_port
	import clp_pkg::*;
#(
	parameter int unsigned LONG_CYCLES  = LONG_CYCLES_DEF,
	parameter int unsigned BLINK_CYCLES = BLINK_CYCLES_DEF,
	parameter int unsigned LINE_CYCLES  = LINE_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// host bus pins
	input  wire logic        register_select,
	input  wire logic        read_write,
	input  wire logic        bus_enable,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe_n,
	// port selection pins
	input  wire logic        port_select_hi,
	input  wire logic        port_select_lo,
	// fixed glyph rom
	output logic      [10:0] rom_addr,
	input  wire logic [4:0]  rom_row,
	// panel driver
	output logic      [39:0] seg_hold,
	output logic      [3:0]  com_index,
	output logic             seg_load,
	output logic             two_line_mode
);

	if (LONG_CYCLES < 1 || LONG_CYCLES > 65535 || LINE_CYCLES < 1 || LINE_CYCLES > 65535
		|| BLINK_CYCLES < 1 || BLINK_CYCLES > 33554431) begin : g_bad
		$error("clp_host_port: timing count out of range");
	end

	function automatic logic [6:0] clp_step(input logic [6:0] a, input logic up, input logic glyph,
		input logic two);
		if (glyph) return {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
		if (two && up) return (a == LINE1_LAST) ? LINE2_FIRST : (a == LINE2_LAST) ? ADDR_FIRST : a + 7'h01;
		if (two) return (a == ADDR_FIRST) ? LINE2_LAST : (a == LINE2_FIRST) ? LINE1_LAST : a - 7'h01;
		if (up) return (a == ONE_LINE_LAST) ? ADDR_FIRST : a + 7'h01;
		return (a == ADDR_FIRST) ? ONE_LINE_LAST : a - 7'h01;
	endfunction

	function automatic logic [6:0] clp_shift_step(input logic [6:0] s, input logic left, input logic two);
		logic [6:0] last;
		last = two ? LINE1_LAST : ONE_LINE_LAST;
		if (left) return (s >= last) ? ADDR_FIRST : s + 7'h01;
		return (s == ADDR_FIRST) ? last : s - 7'h01;
	endfunction

	// pin synchronisers
	logic [12:0] pin_s1_r, pin_s2_r;
	logic        en_d_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_r <= 13'h0000;
			pin_s2_r <= 13'h0000;
			en_d_r   <= 1'b0;
		end else begin
			pin_s1_r <= {register_select, read_write, bus_enable, port_select_hi, port_select_lo, data_in};
			pin_s2_r <= pin_s1_r;
			en_d_r   <= pin_s2_r[10];
		end
	end
	wire       rs_s    = pin_s2_r[12];
	wire       rw_s    = pin_s2_r[11];
	wire       en_s    = pin_s2_r[10];
	wire [7:0] data_s  = pin_s2_r[7:0];
	wire       parallel = (pin_s2_r[9:8] == PSEL_PARALLEL);

	// state registers
	clp_eng_t    eng_state_r;
	logic [6:0]  ac_r, shift_r, clr_idx_r;
	logic [7:0]  cmd_r, dr_r, nib_hi_r, data_out_r;
	logic [15:0] timer_r;
	logic        cmd_pend_r, rd_pend_r, nib_phase_r, tgt_glyph_r;
	logic        dl8_r, two_r, font_r, inc_r, sh_en_r, disp_r, cur_r, blink_r;
	logic        buf_in_ready, buf_out_valid;
	logic [7:0]  buf_out_data, char_a_rdata, glyph_a_rdata, char_b_rdata, glyph_b_rdata;

	// host strobe decode
	wire       strobe_fall = parallel & en_d_r & ~en_s;
	wire       byte_done   = strobe_fall & (dl8_r | nib_phase_r);
	wire [7:0] host_byte   = dl8_r ? data_s : {nib_hi_r[7:4], data_s[7:4]};
	wire       busy        = (eng_state_r != E_IDLE) | cmd_pend_r | rd_pend_r | buf_out_valid | ~buf_in_ready;
	wire       cmd_set     = byte_done & ~rs_s & ~rw_s & ~busy;
	wire       data_set    = byte_done & rs_s & ~rw_s;
	wire       rd_set      = byte_done & rs_s & rw_s;
	wire [7:0] status_val  = {busy & parallel, ac_r};
	wire [7:0] read_val    = rs_s ? dr_r : status_val;
	wire [7:0] drive_val   = dl8_r ? read_val : nib_phase_r ? {read_val[3:0], 4'h0} : {read_val[7:4], 4'h0};

	assign data_out  = data_out_r;
	assign data_oe_n = ~(parallel & en_s & rw_s);

	// engine request arbitration
	wire idle      = (eng_state_r == E_IDLE);
	wire cmd_take  = idle & cmd_pend_r;
	wire data_take = idle & ~cmd_pend_r & buf_out_valid;
	wire rd_take   = idle & ~cmd_pend_r & ~buf_out_valid & rd_pend_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			nib_phase_r <= 1'b0;
			nib_hi_r    <= REG_RESET;
			cmd_r       <= REG_RESET;
			cmd_pend_r  <= 1'b0;
			rd_pend_r   <= 1'b0;
			data_out_r  <= REG_RESET;
		end else begin
			if (strobe_fall) begin
				nib_phase_r <= ~dl8_r & ~nib_phase_r;
				if (!nib_phase_r) nib_hi_r <= data_s;
			end else if (dl8_r) begin
				nib_phase_r <= 1'b0;
			end
			if (cmd_set) cmd_r <= host_byte;
			cmd_pend_r <= cmd_set | (cmd_pend_r & ~cmd_take);
			rd_pend_r  <= rd_set | (rd_pend_r & ~rd_take);
			data_out_r <= drive_val;
		end
	end

	// buffered data writes
	clp_buf2 #(.W(8)) u_buf (
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.in_valid  (data_set),
		.in_ready  (buf_in_ready),
		.in_data   (host_byte),
		.out_valid (buf_out_valid),
		.out_ready (data_take),
		.out_data  (buf_out_data)
	);

	// ram port a steering
	wire       clearing  = (eng_state_r == E_CLEAR);
	wire [6:0] ram_a_addr = clearing ? clr_idx_r : ac_r;
	wire [7:0] ram_a_wdata = clearing ? CLEAR_CHAR : buf_out_data;
	wire       char_we   = clearing | (data_take & ~tgt_glyph_r);
	wire       glyph_we  = data_take & tgt_glyph_r;
	wire       dir_left  = cmd_r[FLD_RL] == 1'b0;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			eng_state_r <= E_IDLE;
			ac_r        <= ADDR_FIRST;
			shift_r     <= ADDR_FIRST;
			clr_idx_r   <= ADDR_FIRST;
			dr_r        <= REG_RESET;
			timer_r     <= 16'h0000;
			tgt_glyph_r <= 1'b0;
			dl8_r       <= 1'b1;
			two_r       <= 1'b0;
			font_r      <= 1'b0;
			inc_r       <= 1'b1;
			sh_en_r     <= 1'b0;
			disp_r      <= 1'b0;
			cur_r       <= 1'b0;
			blink_r     <= 1'b0;
		end else begin
			case (eng_state_r)
			E_IDLE: begin
				timer_r <= 16'(EXEC_CYCLES - 1);
				if (cmd_take) begin
					eng_state_r <= E_EXEC;
					if (cmd_r[CMD_DDADDR_BIT]) begin
						ac_r        <= cmd_r[6:0];
						tgt_glyph_r <= 1'b0;
						eng_state_r <= E_FETCH;
					end else if (cmd_r[CMD_CGADDR_BIT]) begin
						ac_r        <= {1'b0, cmd_r[5:0]};
						tgt_glyph_r <= 1'b1;
						eng_state_r <= E_FETCH;
					end else if (cmd_r[CMD_FUNC_BIT]) begin
						dl8_r   <= cmd_r[FLD_DL];
						two_r   <= cmd_r[FLD_N];
						font_r  <= cmd_r[FLD_F];
						shift_r <= ADDR_FIRST;
					end else if (cmd_r[CMD_SHIFT_BIT]) begin
						if (cmd_r[FLD_SC]) shift_r <= clp_shift_step(shift_r, dir_left, two_r);
						else ac_r <= clp_step(ac_r, ~dir_left, tgt_glyph_r, two_r);
					end else if (cmd_r[CMD_DISP_BIT]) begin
						disp_r  <= cmd_r[FLD_DISP_ON];
						cur_r   <= cmd_r[FLD_CURSOR];
						blink_r <= cmd_r[FLD_BLINK];
					end else if (cmd_r[CMD_ENTRY_BIT]) begin
						inc_r   <= cmd_r[FLD_ID];
						sh_en_r <= cmd_r[FLD_S];
					end else if (cmd_r[CMD_HOME_BIT]) begin
						ac_r        <= ADDR_FIRST;
						shift_r     <= ADDR_FIRST;
						tgt_glyph_r <= 1'b0;
						timer_r     <= 16'(LONG_CYCLES - 1);
					end else if (cmd_r[CMD_CLEAR_BIT]) begin
						ac_r        <= ADDR_FIRST;
						shift_r     <= ADDR_FIRST;
						inc_r       <= 1'b1;
						tgt_glyph_r <= 1'b0;
						clr_idx_r   <= ADDR_FIRST;
						eng_state_r <= E_CLEAR;
					end else begin
						eng_state_r <= E_IDLE;
					end
				end else if (data_take) begin
					ac_r        <= clp_step(ac_r, inc_r, tgt_glyph_r, two_r);
					if (sh_en_r && !tgt_glyph_r) shift_r <= clp_shift_step(shift_r, inc_r, two_r);
					eng_state_r <= E_EXEC;
				end else if (rd_take) begin
					ac_r        <= clp_step(ac_r, inc_r, tgt_glyph_r, two_r);
					eng_state_r <= E_FETCH;
				end
			end
			E_CLEAR: begin
				clr_idx_r <= clr_idx_r + 7'h01;
				if (clr_idx_r == ADDR_TOP) begin
					timer_r     <= 16'(LONG_CYCLES - 1);
					eng_state_r <= E_EXEC;
				end
			end
			E_FETCH: eng_state_r <= E_CAPT;
			E_CAPT: begin
				dr_r        <= tgt_glyph_r ? glyph_a_rdata : char_a_rdata;
				timer_r     <= 16'(EXEC_CYCLES - 1);
				eng_state_r <= E_EXEC;
			end
			E_EXEC: begin
				if (timer_r == 16'h0000) eng_state_r <= E_IDLE;
				else timer_r <= timer_r - 16'h0001;
			end
			default: eng_state_r <= E_IDLE;
			endcase
		end
	end

	// display scan
	clp_scan_t  scan_r;
	logic [3:0] row_r;
	logic [2:0] pos_r, bit_r;
	logic [4:0] pat_r;
	logic [7:0] code_r;
	logic       cur_here_r, blink_ph_r, line_tick_r;
	logic [39:0] chain_r;
	logic [24:0] blink_cnt_r;
	logic [15:0] line_cnt_r;

	wire       line2     = two_r & row_r[3];
	wire [6:0] pos_sum   = {4'h0, pos_r} + shift_r;
	wire [6:0] line_len  = two_r ? TWO_LINE_LEN : ONE_LINE_LEN;
	wire [6:0] pos_wrap  = (pos_sum >= line_len) ? pos_sum - line_len : pos_sum;
	wire [6:0] scan_addr = pos_wrap | (line2 ? LINE2_FIRST : ADDR_FIRST);
	wire       user_code = (code_r[7:4] == USER_GLYPH_HI);
	wire [5:0] glyph_b_addr = {code_r[2:0], row_r[2:0]};
	wire [4:0] raw_row   = user_code ? glyph_b_rdata[4:0] : rom_row;
	wire [4:0] cur_row   = (cur_here_r && cur_r && row_r[2:0] == CURSOR_ROW) ? 5'h1F : raw_row;
	wire [4:0] shown_row = ~disp_r ? 5'h00 : (cur_here_r && blink_r && blink_ph_r) ? ~cur_row : cur_row;
	wire [3:0] last_row  = two_r ? LAST_COM_TWO : LAST_COM_ONE;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			blink_cnt_r <= 25'h0000000;
			blink_ph_r  <= 1'b0;
			line_cnt_r  <= 16'h0000;
			line_tick_r <= 1'b0;
		end else begin
			line_tick_r <= (line_cnt_r == 16'(LINE_CYCLES - 1));
			line_cnt_r  <= (line_cnt_r == 16'(LINE_CYCLES - 1)) ? 16'h0000 : line_cnt_r + 16'h0001;
			if (blink_cnt_r == 25'(BLINK_CYCLES - 1)) begin
				blink_cnt_r <= 25'h0000000;
				blink_ph_r  <= ~blink_ph_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 25'h0000001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			scan_r     <= S_ADDR;
			row_r      <= 4'h0;
			pos_r      <= 3'h0;
			bit_r      <= 3'h0;
			pat_r      <= 5'h00;
			code_r     <= REG_RESET;
			cur_here_r <= 1'b0;
			chain_r    <= 40'h0000000000;
			seg_hold   <= 40'h0000000000;
			com_index  <= 4'h0;
			seg_load   <= 1'b0;
			rom_addr   <= 11'h000;
		end else begin
			seg_load <= 1'b0;
			case (scan_r)
			S_ADDR: scan_r <= S_CODE;
			S_CODE: begin
				code_r     <= char_b_rdata;
				rom_addr   <= {char_b_rdata, row_r[2:0]};
				cur_here_r <= ~tgt_glyph_r & (scan_addr == ac_r);
				scan_r     <= S_GLYPH;
			end
			S_GLYPH: scan_r <= S_ROW;
			S_ROW: begin
				pat_r  <= shown_row;
				bit_r  <= 3'h0;
				scan_r <= S_SHIFT;
			end
			S_SHIFT: begin
				chain_r <= {chain_r[SEG_COUNT-2:0], pat_r[SEG_PER_CHAR-1]};
				pat_r   <= {pat_r[3:0], 1'b0};
				bit_r   <= bit_r + 3'h1;
				if (bit_r == LAST_SEG_BIT) begin
					pos_r  <= pos_r + 3'h1;
					scan_r <= (pos_r == LAST_POS) ? S_LOAD : S_ADDR;
				end
			end
			S_LOAD: begin
				seg_hold  <= chain_r;
				com_index <= row_r;
				seg_load  <= 1'b1;
				scan_r    <= S_WAIT;
			end
			S_WAIT: begin
				if (line_tick_r) begin
					row_r  <= (row_r >= last_row) ? 4'h0 : row_r + 4'h1;
					pos_r  <= 3'h0;
					scan_r <= S_ADDR;
				end
			end
			default: scan_r <= S_ADDR;
			endcase
		end
	end

	assign two_line_mode = two_r;

	// character code ram, 128 locations of which the maps use 80
	clp_dpram #(.W(8), .AW(CHAR_AW)) u_char_code_ram (
		.sys_clk (sys_clk),
		.a_addr  (ram_a_addr),
		.a_we    (char_we),
		.a_wdata (ram_a_wdata),
		.a_rdata (char_a_rdata),
		.b_addr  (scan_addr),
		.b_rdata (char_b_rdata)
	);

	// user glyph ram, 8 glyphs of 8 rows
	clp_dpram #(.W(8), .AW(GLYPH_AW)) u_user_glyph_ram (
		.sys_clk (sys_clk),
		.a_addr  (ac_r[5:0]),
		.a_we    (glyph_we),
		.a_wdata (buf_out_data),
		.a_rdata (glyph_a_rdata),
		.b_addr  (glyph_b_addr),
		.b_rdata (glyph_b_rdata)
	);

endmodule

// ### tb/clp_port_monitor.sv
`timescale 1ns/1ps
module clp_port_chk (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        arst_n,
	// host pins
	input wire logic        register_select,
	input wire logic        read_write,
	input wire logic        bus_enable,
	input wire logic [7:0]  data_out,
	input wire logic        data_oe_n,
	input wire logic        port_select_hi,
	input wire logic        port_select_lo,
	// panel
	input wire logic [39:0] seg_hold,
	input wire logic [3:0]  com_index,
	input wire logic        seg_load,
	input wire logic        two_line_mode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	chk_oe_cause: assert property (
		!data_oe_n |-> ($past(read_write, 2) || $past(read_write, 3) || $past(read_write, 4))
		&& ($past(bus_enable, 2) || $past(bus_enable, 3) || $past(bus_enable, 4)))
		else $error("data lines driven without a read strobe");
	chk_write_quiet: assert property (
		(!read_write)[*4] |=> data_oe_n) else $error("data lines driven during a write");
	chk_idle_quiet: assert property (
		(!bus_enable)[*4] |=> data_oe_n) else $error("data lines driven while not enabled");
	chk_serial_quiet: assert property (
		(port_select_hi || port_select_lo)[*4] |=> data_oe_n) else $error("parallel bus active in serial mode");
	chk_load_gap: assert property (
		seg_load |=> (!seg_load)[*8]) else $error("segment load pulses too close");
	chk_seg_changed: assert property (
		$changed(seg_hold) |-> seg_load) else $error("holding latch changed without load");
	chk_com_changed: assert property (
		$changed(com_index) |-> seg_load) else $error("common index changed without load");
	chk_com_range: assert property (
		seg_load && !two_line_mode |-> com_index <= 4'h7) else $error("common index beyond one-line range");
	chk_reset_state: assert property (
		$rose(arst_n) |-> data_oe_n && data_out == 8'h00 && !seg_load && com_index == 4'h0)
		else $error("outputs not at reset state");
endmodule

bind clp_host_port clp_port_chk u_chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .register_select(register_select), .read_write(read_write),
	.bus_enable(bus_enable), .data_out(data_out), .data_oe_n(data_oe_n), .port_select_hi(port_select_hi),
	.port_select_lo(port_select_lo), .seg_hold(seg_hold), .com_index(com_index), .seg_load(seg_load),
	.two_line_mode(two_line_mode));

// ### tb/clp_host_model.sv
`timescale 1ns/1ps
module clp_host_model (
	// clock
	input wire logic        sys_clk,
	// bus pins
	output logic            register_select,
	output logic            read_write,
	output logic            bus_enable,
	output logic      [7:0] data_in,
	input wire logic  [7:0] data_out,
	input wire logic        data_oe_n
);
	logic [7:0] drv;
	logic       drv_en;

	// released lines show the inverse of the last value, not a stale copy
	assign data_in = !data_oe_n ? data_out : (drv_en ? drv : ~drv);

	initial begin
		register_select = 1'b0;
		read_write = 1'b1;
		bus_enable = 1'b0;
		drv = 8'h00;
		drv_en = 1'b0;
	end

	// one strobe: pins settle with enable, read at the last edge before the fall
	task automatic xfer(input logic rs, input logic rw, input logic [7:0] wd, output logic [7:0] rd);
		@(negedge sys_clk);
		register_select = rs;
		read_write = rw;
		drv = wd;
		drv_en = !rw;
		bus_enable = 1'b1;
		repeat (8) @(negedge sys_clk);
		rd = data_out;
		bus_enable = 1'b0;
		repeat (12) @(negedge sys_clk);
		drv_en = 1'b0;
	endtask
endmodule

// ### tb/tb_clp_host_port.sv
`timescale 1ns/1ps
module tb_clp_host_port;
	import clp_pkg::*;
	logic        sys_clk, arst_n, register_select, read_write, bus_enable, data_oe_n;
	logic        port_select_hi, port_select_lo, seg_load, two_line_mode;
	logic [7:0]  data_in, data_out;
	logic [10:0] rom_addr;
	logic [4:0]  rom_row;
	logic [39:0] seg_hold;
	logic [3:0]  com_index;
	int          fail_count = 0;
	int          n_checks = 0;
	int          base = 0;
	logic        nib = 1'b0;
	logic        inc = 1'b1;
	logic [6:0]  ac = 7'h00;
	logic [7:0]  mem [0:191];

	clp_host_port #(.LONG_CYCLES(20), .BLINK_CYCLES(50), .LINE_CYCLES(200)) dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .register_select(register_select), .read_write(read_write),
		.bus_enable(bus_enable), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.port_select_hi(port_select_hi), .port_select_lo(port_select_lo), .rom_addr(rom_addr),
		.rom_row(rom_row), .seg_hold(seg_hold), .com_index(com_index), .seg_load(seg_load),
		.two_line_mode(two_line_mode));
	clp_host_model host (.sys_clk(sys_clk), .register_select(register_select), .read_write(read_write),
		.bus_enable(bus_enable), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// stand-in for the fixed glyph rom: dots are a simple hash of the address
	function automatic logic [4:0] rom_dots(input logic [10:0] a);
		return a[4:0] ^ a[10:6];
	endfunction
	initial rom_row = 5'h00;
	always @(posedge sys_clk) rom_row <= rom_dots(rom_addr);

	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one-line character map runs 00 to 4F and wraps; glyph addresses wrap in six bits
	function automatic logic [6:0] step(input logic [6:0] a, input logic up);
		if (base != 0) return {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
		if (up) return (a == ONE_LINE_LAST) ? ADDR_FIRST : a + 7'h01;
		return (a == ADDR_FIRST) ? ONE_LINE_LAST : a - 7'h01;
	endfunction
	// one byte, split into high then low nibble on the upper lines in 4-bit mode
	task automatic xb(input logic rs, input logic rw, input logic [7:0] wd, output logic [7:0] rd);
		logic [7:0] h, l;
		if (nib) begin
			host.xfer(rs, rw, {wd[7:4], 4'h0}, h);
			host.xfer(rs, rw, {wd[3:0], 4'h0}, l);
			rd = {h[7:4], l[7:4]};
			if (rw) check({h[3:0], l[3:0]}, 8'h00, "unused low lines");
		end else host.xfer(rs, rw, wd, rd);
	endtask
	task automatic wait_idle();
		logic [7:0] s;
		for (int i = 0; i < 100; i++) begin
			xb(1'b0, 1'b1, 8'h00, s);
			if (s[7] === 1'b0) return;
		end
		fail_count++;
		$display("[FAIL] %0t busy never cleared", $time);
		report_and_stop();
	endtask
	task automatic cmd(input logic [7:0] c);
		logic [7:0] d;
		wait_idle();
		xb(1'b0, 1'b0, c, d);
	endtask
	task automatic setad(input logic cg, input logic [6:0] a);
		cmd(cg ? {2'b01, a[5:0]} : {1'b1, a});
		base = cg ? 128 : 0;
		ac = a;
	endtask
	task automatic chk_ac(input string w);
		logic [7:0] s;
		wait_idle();
		xb(1'b0, 1'b1, 8'h00, s);
		check(s, {1'b0, ac}, w);
	endtask
	task automatic wr(input logic [7:0] b);
		logic [7:0] d;
		wait_idle();
		xb(1'b1, 1'b0, b, d);
		mem[base + int'(ac)] = b;
		ac = step(ac, inc);
	endtask
	task automatic rdchk();
		logic [7:0] d;
		wait_idle();
		xb(1'b1, 1'b1, 8'h00, d);
		check(d, mem[base + int'(ac)], "data read");
		ac = step(ac, inc);
	endtask

	initial begin
		repeat (95000) @(posedge sys_clk);
		fail_count++;
		$display("[FAIL] %0t run timed out", $time);
		report_and_stop();
	end

	initial begin
		logic [7:0] d;
		logic [6:0] a;
		int         seen;
		arst_n = 1'b0;
		port_select_hi = 1'b0;
		port_select_lo = 1'b0;
		d = 8'($urandom(60875));
		repeat (12) @(posedge sys_clk);
		check({data_oe_n, seg_load, data_out[5:0]}, 8'h80, "reset outputs");
		@(negedge sys_clk) arst_n = 1'b1;
		chk_ac("status after reset");
		cmd(8'h0C);
		xb(1'b0, 1'b1, 8'h00, d);
		check({d[7], 7'h00}, 8'h80, "busy after command");
		for (int k = 0; k < 3; k++) begin
			a = (k == 0) ? 7'h4A : 7'($urandom_range(0, 74));
			setad(1'b0, a);
			chk_ac("counter loaded, command unreadable");
			for (int j = 0; j < 6; j++) wr(8'($urandom));
			chk_ac("counter after writes");
			setad(1'b0, a);
			for (int j = 0; j < 6; j++) rdchk();
		end
		cmd(8'h04);
		inc = 1'b0;
		setad(1'b0, 7'h10);
		wr(8'h5A);
		chk_ac("counter after decrement");
		setad(1'b0, 7'h10);
		rdchk();
		cmd(8'h06);
		inc = 1'b1;
		a = 7'($urandom_range(0, 56));
		setad(1'b1, a);
		for (int j = 0; j < 4; j++) wr(8'($urandom));
		chk_ac("glyph counter");
		setad(1'b1, a);
		for (int j = 0; j < 4; j++) rdchk();
		for (int m = 1; m < 4; m++) begin
			@(negedge sys_clk) {port_select_hi, port_select_lo} = 2'(m);
			xb(1'b0, 1'b0, 8'hB3, d);
			xb(1'b1, 1'b0, 8'hEE, d);
			xb(1'b0, 1'b1, 8'h00, d);
		end
		@(negedge sys_clk) {port_select_hi, port_select_lo} = 2'b00;
		chk_ac("serial strobes ignored");
		cmd(8'h20);
		nib = 1'b1;
		setad(1'b0, 7'h2A);
		chk_ac("nibble status");
		wr(8'hC3);
		setad(1'b0, 7'h2A);
		rdchk();
		cmd(8'h30);
		nib = 1'b0;
		chk_ac("back to byte width");
		// clear fills every cell with the blank code, so each panel row is predictable
		cmd(8'h01);
		cmd(8'h38);
		wait_idle();
		check({7'h00, two_line_mode}, 8'h01, "two-line mode");
		seen = 0;
		for (int c = 0; c < 8000 && seen == 0; c++) begin
			@(negedge sys_clk);
			if (seg_load === 1'b1 && com_index > 4'h7) begin
				seen = 1;
				check(seg_hold, {8{rom_dots({CLEAR_CHAR, com_index[2:0]})}}, "blank row pattern");
				check(rom_addr[10:3], CLEAR_CHAR, "glyph code after clear");
			end
		end
		check(8'(seen), 8'h01, "upper commons used");
		report_and_stop();
	end
endmodule
